// >>> shared/fsr_pkg.sv
// Constants shared by the flash status register bank and its helpers.
package fsr_pkg;

    // ---------------------------------------------------------------
    // Opcodes seen on the serial link.
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_READ_ONE = 8'h05;
    localparam logic [7:0] OP_READ_TWO = 8'h35;
    localparam logic [7:0] OP_READ_THREE = 8'h15;
    localparam logic [7:0] OP_WRITE_ONE = 8'h01;
    localparam logic [7:0] OP_WRITE_TWO = 8'h31;
    localparam logic [7:0] OP_WRITE_THREE = 8'h11;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;

    // ---------------------------------------------------------------
    // Frame lengths, counted in serial clock edges.
    // ---------------------------------------------------------------
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_WRITE = 5'h10;
    localparam logic [4:0] BITS_MAX = 5'h1f;
    localparam logic [4:0] BIT_LAST_OPCODE = 5'h07;
    localparam logic [4:0] BIT_LAST_DATA = 5'h0f;
    localparam logic [2:0] BIT_PTR_FIRST = 3'h0;

    // ---------------------------------------------------------------
    // Field positions inside the three status bytes.
    // ---------------------------------------------------------------
    localparam int ONE_PROTECT_LOW = 7;
    localparam int ONE_GUARD_HI = 6;
    localparam int ONE_GUARD_LO = 2;
    localparam int ONE_WRITE_LATCH = 1;
    localparam int ONE_BUSY = 0;
    localparam int TWO_ERASE_PAUSED = 7;
    localparam int TWO_GUARD_INVERT = 6;
    localparam int TWO_LOCK_HI = 5;
    localparam int TWO_LOCK_LO = 3;
    localparam int TWO_PROGRAM_PAUSED = 2;
    localparam int TWO_FOUR_LANE = 1;
    localparam int TWO_PROTECT_HIGH = 0;
    localparam int THREE_STRENGTH_HI = 6;
    localparam int THREE_STRENGTH_LO = 5;

    // Bits that a status write may change; all others are read-only or reserved.
    localparam logic [7:0] MASK_ONE = 8'hfc;
    localparam logic [7:0] MASK_TWO = 8'h7b;
    localparam logic [7:0] MASK_THREE = 8'h60;

    // ---------------------------------------------------------------
    // Values after reset.
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_ONE = 8'h00;
    localparam logic [7:0] RST_TWO = 8'h00;
    localparam logic [7:0] RST_THREE = 8'h60;
    localparam logic [23:0] RST_SHADOW = 24'h000000;

    // ---------------------------------------------------------------
    // Self-timed status write cycle.
    // ---------------------------------------------------------------
    localparam int CORE_CLK_NS = 20;
    localparam int WRITE_CYCLE_NS = 10000;
    localparam int WRITE_CYCLE_INT = (WRITE_CYCLE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam logic [11:0] WRITE_CYCLES = WRITE_CYCLE_INT[11:0];
    localparam logic [11:0] TIMER_IDLE = 12'h000;

endpackage

// >>> rtl/fsr_sync.sv
// Two flip-flop synchroniser for a group of independent levels.
module fsr_sync
    import fsr_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage; nothing else reads it.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule // fsr_sync

// >>> rtl/fsr_bank.sv
// Status and configuration register bank of a serial flash, with its link-side shifter.
//
// Notes on behaviour
// - Status reads are served at any time, even during a self-timed operation.
// - After opcode 05h the device streams status byte one, one bit per clock.
// - After bit 0 the stream restarts at bit 7 while select stays low.
// - Each repetition shows the current state, so busy changes appear live.
// - Releasing select ends the read at once and floats the serial output.
// - Opcode 35h streams status byte two in the same repeating way.
// - Status byte three is read with opcode 15h and written with 11h.
// - Byte one: protect low, five guards, write latch, busy, from bit 7 down.
// - Write latch reads 0 when not write enabled, 1 when enabled.
// - Busy flag reads 0 when ready, 1 during an internal operation.
// - Writes change only writable bits; latch, busy and suspend flags stay.
// - Byte two bit 7 is the read-only erase-suspended flag, default 0.
// - Byte two bit 2 is the read-only program-suspended flag, default 0.
// - Byte two bit 6 is the writable guard invert bit, default 0.
// - Byte two bits 5..3 are page locks, default 0; 1 blocks that page.
// - Byte two bit 1 enables four lanes; hold and protect pins become data.
// - Byte three bits 6:5 hold drive strength, default 11.
// - Byte two bit 0 is protect high; with protect low and pin sets locking.
// - Both protect bits 0: writes accepted whenever the latch is set.
// - Protect high 0, low 1: writes rejected while the protect pin is low.
// - Protect high 0, low 1, pin high: writes accepted with the latch set.
// - Protect high 1, low 0: writes rejected until power cycle clears both.
// - Latch clear refuses modifying commands; latch is 0 after reset.
// - Status write must end right after eighth data bit, else discarded.
module fsr_bank
    import fsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic serial_clk,
    input wire logic sel_n,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe,
    input wire logic write_protect_n,
    input wire logic array_busy,
    input wire logic erase_paused_flag,
    input wire logic program_paused_flag,
    output logic write_latch,
    output logic ready_busy_flag,
    output logic [4:0] region_guard,
    output logic guard_invert,
    output logic [2:0] page_lock,
    output logic four_lane_enable,
    output logic [1:0] output_strength_field
);

    // ---------------------------------------------------------------
    // Link domain: runs on the serial clock; counters, handshake and output cleared while select is high.
    // ---------------------------------------------------------------

    logic [4:0] bit_cnt_q;
    logic [2:0] bit_ptr_q;
    logic [7:0] shift_q;
    logic [7:0] frame_op_q;
    logic [7:0] frame_data_q;
    logic [4:0] frame_bits_q;
    logic req_meta_q;
    logic req_link_q;
    logic ack_q;
    logic [23:0] copy_q;
    logic [7:0] out_shift_q;
    logic serial_out_q;
    logic reading_q;
    logic [4:0] bit_cnt_inc;
    logic op_is_read;
    logic [7:0] read_byte;
    // Core-side half of the snapshot handshake, read by the link logic below.
    logic req_q;
    logic [23:0] shadow_q;

    // Saturating edge count; the frame length is all the core needs beyond opcode and data.
    assign bit_cnt_inc = (bit_cnt_q == BITS_MAX) ? BITS_MAX : bit_cnt_q + 5'h01;
    assign op_is_read = (frame_op_q == OP_READ_ONE) || (frame_op_q == OP_READ_TWO)
                        || (frame_op_q == OP_READ_THREE);

    // Byte picked by the opcode from the freshest snapshot of the core state.
    assign read_byte = (frame_op_q == OP_READ_TWO) ? copy_q[15:8] :
                       (frame_op_q == OP_READ_THREE) ? copy_q[7:0] :
                       copy_q[23:16];

    // Input sampling on the rising edge; select high clears the counters at once.
    always_ff @(posedge serial_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            bit_cnt_q <= 5'h00;
            bit_ptr_q <= BIT_PTR_FIRST;
            shift_q <= 8'h00;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_inc;
            bit_ptr_q <= (bit_cnt_q >= BITS_OPCODE) ? bit_ptr_q + 3'h1 : BIT_PTR_FIRST;
            shift_q <= {shift_q[6:0], serial_in};
        end
    end

    // Frame summary for the core. It is not cleared by select, so it stays put after
    // the frame until the core has taken it over; the clock stops between frames.
    always_ff @(posedge serial_clk)
    begin
        if (!sel_n && bit_cnt_q == BIT_LAST_OPCODE)
        begin
            frame_op_q <= {shift_q[6:0], serial_in};
        end
        if (!sel_n && bit_cnt_q == BIT_LAST_DATA)
        begin
            frame_data_q <= {shift_q[6:0], serial_in};
        end
        if (!sel_n)
        begin
            frame_bits_q <= bit_cnt_inc;
        end
    end

    // Request synchroniser and acknowledge of the snapshot handshake.
    always_ff @(posedge serial_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            req_meta_q <= 1'b0;
            req_link_q <= 1'b0;
            ack_q <= 1'b0;
        end
        else
        begin
            req_meta_q <= req_q;
            req_link_q <= req_meta_q;
            ack_q <= req_link_q;
        end
    end

    // Snapshot is taken only when a new request arrives, so the core holds it steady.
    always_ff @(posedge serial_clk)
    begin
        if (!sel_n && req_link_q != ack_q)
        begin
            copy_q <= shadow_q;
        end
    end

    // Output on the falling edge: the byte is reloaded at each bit 7 so every pass
    // carries the newest snapshot, then shifted out most significant bit first.
    always_ff @(negedge serial_clk or posedge sel_n)
    begin
        if (sel_n)
        begin
            out_shift_q <= 8'h00;
            serial_out_q <= 1'b0;
            reading_q <= 1'b0;
        end
        else if (bit_cnt_q >= BITS_OPCODE && op_is_read)
        begin
            reading_q <= 1'b1;
            if (bit_ptr_q == BIT_PTR_FIRST)
            begin
                serial_out_q <= read_byte[7];
                out_shift_q <= {read_byte[6:0], 1'b0};
            end
            else
            begin
                serial_out_q <= out_shift_q[7];
                out_shift_q <= {out_shift_q[6:0], 1'b0};
            end
        end
    end

    assign serial_out = serial_out_q;
    assign serial_out_oe = reading_q;

    // ---------------------------------------------------------------
    // Crossings into the core domain.
    // ---------------------------------------------------------------

    logic [2:0] pins_raw;
    logic [2:0] pins_sync;
    logic sel_n_s;
    logic protect_pin_s;
    logic ack_s;

    assign pins_raw = {sel_n, write_protect_n, ack_q};

    fsr_sync #(
        .WIDTH(3),
        .RST_VAL(3'b110)
    ) u_sync (
        .clk(core_clk),
        .rst(srst),
        .d(pins_raw),
        .q(pins_sync)
    );

    assign sel_n_s = pins_sync[2];
    assign protect_pin_s = pins_sync[1];
    assign ack_s = pins_sync[0];

    // ---------------------------------------------------------------
    // Core domain: stored fields, protection and command decode.
    // ---------------------------------------------------------------

    logic sel_n_prev_q;
    logic [7:0] one_q;
    logic [7:0] two_q;
    logic [7:0] three_q;
    logic latch_q;
    logic [11:0] timer_q;
    logic frame_end;
    logic timer_busy;
    logic timer_done;
    logic protect_high;
    logic protect_low;
    logic write_locked;
    logic is_status_write;
    logic write_length_ok;
    logic write_accept;
    logic write_discard;
    logic latch_set;
    logic latch_clr;
    logic busy_now;
    logic [7:0] live_one;
    logic [7:0] live_two;
    logic [7:0] live_three;

    // Select rising as seen through the synchroniser closes a frame.
    assign frame_end = sel_n_s && !sel_n_prev_q;
    assign timer_busy = (timer_q != TIMER_IDLE);
    assign timer_done = (timer_q == 12'h001);
    assign busy_now = array_busy || timer_busy;

    // Protection state from the two protect bits and the pin.
    assign protect_high = two_q[TWO_PROTECT_HIGH];
    assign protect_low = one_q[ONE_PROTECT_LOW];
    assign write_locked = protect_high
                          || (protect_low && !protect_pin_s);

    // A status write is honoured only when the frame ends right after its data byte.
    assign is_status_write = (frame_op_q == OP_WRITE_ONE) || (frame_op_q == OP_WRITE_TWO)
                             || (frame_op_q == OP_WRITE_THREE);
    assign write_length_ok = (frame_bits_q == BITS_WRITE);
    assign write_accept = frame_end && is_status_write && write_length_ok && !timer_busy
                          && latch_q && !write_locked;
    assign write_discard = frame_end && is_status_write && !write_accept
                           && (frame_bits_q >= BITS_OPCODE);

    // Latch control; while the write cycle runs enable and disable are ignored, but a discarded write or the cycle's end clears the latch.
    assign latch_set = frame_end && !timer_busy && (frame_bits_q == BITS_OPCODE)
                       && (frame_op_q == OP_WRITE_ENABLE);
    assign latch_clr = (frame_end && !timer_busy && (frame_bits_q == BITS_OPCODE)
                        && (frame_op_q == OP_WRITE_DISABLE)) || write_discard || timer_done;

    // Live byte images; read-only flags come straight from the device state.
    assign live_one = {one_q[7:2], latch_q, busy_now};
    assign live_two = {erase_paused_flag, two_q[6:3], program_paused_flag,
                       two_q[1:0]};
    assign live_three = three_q & MASK_THREE;

    // Edge tracker for select.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sel_n_prev_q <= 1'b1;
        end
        else
        begin
            sel_n_prev_q <= sel_n_s;
        end
    end

    // Snapshot handshake: with select low, refresh the shadow only after the link took the last one,
    // which keeps every word crossing stable for the whole synchroniser delay.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            req_q <= 1'b0;
            shadow_q <= RST_SHADOW;
        end
        else if (sel_n_s)
        begin
            req_q <= 1'b0;
            shadow_q <= {live_one, live_two, live_three};
        end
        else if (ack_s == req_q)
        begin
            req_q <= !req_q;
            shadow_q <= {live_one, live_two, live_three};
        end
    end

    // Writable fields; reset plays the role of a power cycle and frees a lockdown.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            one_q <= RST_ONE;
            two_q <= RST_TWO;
            three_q <= RST_THREE;
        end
        else if (write_accept && frame_op_q == OP_WRITE_ONE)
        begin
            one_q <= frame_data_q & MASK_ONE;
        end
        else if (write_accept && frame_op_q == OP_WRITE_TWO)
        begin
            two_q <= frame_data_q & MASK_TWO;
        end
        else if (write_accept && frame_op_q == OP_WRITE_THREE)
        begin
            three_q <= frame_data_q & MASK_THREE;
        end
    end

    // Write latch: a set in the same cycle as a clear wins, so no enable is lost.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            latch_q <= 1'b0;
        end
        else if (latch_set)
        begin
            latch_q <= 1'b1;
        end
        else if (latch_clr)
        begin
            latch_q <= 1'b0;
        end
    end

    // Self-timed write cycle; it starts at the select rising that closed the write.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            timer_q <= TIMER_IDLE;
        end
        else if (write_accept)
        begin
            timer_q <= WRITE_CYCLES;
        end
        else if (timer_busy)
        begin
            timer_q <= timer_q - 12'h001;
        end
    end

    // ---------------------------------------------------------------
    // Configuration outputs for the rest of the device.
    // ---------------------------------------------------------------

    // The array engine must refuse modifying commands while this is low.
    assign write_latch = latch_q;
    assign ready_busy_flag = busy_now;
    assign region_guard = one_q[ONE_GUARD_HI:ONE_GUARD_LO];
    assign guard_invert = two_q[TWO_GUARD_INVERT];
    // A set lock bit blocks erase and program of its page in the array engine.
    assign page_lock = two_q[TWO_LOCK_HI:TWO_LOCK_LO];
    // Pad logic turns hold and protect pins into data lanes when this is high.
    assign four_lane_enable = two_q[TWO_FOUR_LANE];
    assign output_strength_field = three_q[THREE_STRENGTH_HI:THREE_STRENGTH_LO];

endmodule // fsr_bank

// >>> testbench/fsr_bank_props.sv
// Port-level checker for the status register bank.
module fsr_bank_props
    import fsr_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sel_n,
    input wire logic serial_out_oe,
    input wire logic array_busy,
    input wire logic write_latch,
    input wire logic ready_busy_flag,
    input wire logic [4:0] region_guard,
    input wire logic guard_invert,
    input wire logic [2:0] page_lock,
    input wire logic four_lane_enable,
    input wire logic [1:0] output_strength_field
);
    // All writable fields except the two protect bits in one group, so a stray update there is caught.
    logic [11:0] cfg;
    assign cfg = {region_guard, guard_invert, page_lock, four_lane_enable, output_strength_field};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_float_idle;
        sel_n |-> !serial_out_oe;
    endproperty
    a_float_idle: assert property (p_float_idle) else $error("output driven while idle");
    property p_latch_reset;
        disable iff (1'b0) srst |=> !write_latch;
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latch set after reset");
    property p_cfg_reset;
        disable iff (1'b0) srst |=> cfg == 12'h003;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("bad field reset");
    property p_busy_array;
        array_busy |-> ready_busy_flag;
    endproperty
    a_busy_array: assert property (p_busy_array) else $error("busy flag misses engine");
    property p_cfg_quiet;
        (!sel_n) [*6] |=> $stable(cfg);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("fields moved inside a frame");
    property p_cfg_latch;
        $changed(cfg) && !$past(srst) |-> $past(write_latch);
    endproperty
    a_cfg_latch: assert property (p_cfg_latch) else $error("write without latch");
    property p_cfg_busy;
        $changed(cfg) && !$past(srst) |-> ##[0:1] ready_busy_flag;
    endproperty
    a_cfg_busy: assert property (p_cfg_busy) else $error("write did not go busy");
    property p_done_latch;
        $fell(ready_busy_flag) && !$past(array_busy) |-> !write_latch;
    endproperty
    a_done_latch: assert property (p_done_latch) else $error("latch kept after write");
    property p_cycle_long;
        $rose(ready_busy_flag) && !array_busy |=> ready_busy_flag [*8];
    endproperty
    a_cycle_long: assert property (p_cycle_long) else $error("write cycle too short");
endmodule // fsr_bank_props

bind fsr_bank fsr_bank_props u_props (
    .core_clk(core_clk), .srst(srst), .sel_n(sel_n), .serial_out_oe(serial_out_oe),
    .array_busy(array_busy), .write_latch(write_latch), .ready_busy_flag(ready_busy_flag),
    .region_guard(region_guard), .guard_invert(guard_invert), .page_lock(page_lock),
    .four_lane_enable(four_lane_enable), .output_strength_field(output_strength_field)
);

// >>> testbench/fsr_host_model.sv
// Behavioural host controller driving the serial link in mode 0.
module fsr_host_model
(
    output logic serial_clk,
    output logic sel_n,
    output logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 80;

    // Clock parks low between frames; it never runs free.
    initial
    begin
        serial_clk = 1'b0;
        sel_n = 1'b1;
        serial_in = 1'b1;
    end

    // Sends ntx bits of tx MSB first, then captures nrx bits into rx.
    task automatic xfer(input logic [15:0] tx, input int ntx, input int nrx,
                        output logic [15:0] rx);
        rx = '0;
        #13;
        sel_n = 1'b0;
        #HALF_NS;
        for (int i = 0; i < ntx + nrx; i++)
        begin
            if (i < ntx)
                serial_in = tx[15 - i];
            else
                serial_in = ~serial_in; // A toggling line, so no stale level looks valid.
            #HALF_NS;
            serial_clk = 1'b1;
            if (i >= ntx)
                rx = {rx[14:0], serial_out_oe ? serial_out : 1'bx};
            #HALF_NS;
            serial_clk = 1'b0;
        end
        #HALF_NS;
        sel_n = 1'b1;
        #200; // Select stays high long enough for the core to take the frame.
    endtask
endmodule // fsr_host_model

// >>> testbench/flash_status_register_bank_bench.sv
// Self-checking bench for the flash status register bank.
module flash_status_register_bank_bench
    import fsr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [7:0] wr_op; logic [7:0] data; logic [7:0] rd_op;
        logic [7:0] exp;} fsr_row_s;
    // An opcode of zero means read only.
    localparam fsr_row_s ROWS [10] = '{
        '{8'h00, 8'h00, OP_READ_ONE, 8'h00}, '{8'h00, 8'h00, OP_READ_TWO, 8'h00},
        '{8'h00, 8'h00, OP_READ_THREE, 8'h60}, '{OP_WRITE_ONE, 8'h7f, OP_READ_ONE, 8'h7c},
        '{OP_WRITE_TWO, 8'hfe, OP_READ_TWO, 8'h7a}, '{OP_WRITE_THREE, 8'hff, OP_READ_THREE, 8'h60},
        '{OP_WRITE_THREE, 8'h00, OP_READ_THREE, 8'h00},
        '{OP_WRITE_THREE, 8'h20, OP_READ_THREE, 8'h20},
        '{OP_WRITE_THREE, 8'h40, OP_READ_THREE, 8'h40}, '{OP_WRITE_TWO, 8'h00, OP_READ_TWO, 8'h00}};

    logic core_clk, srst, serial_clk, sel_n, serial_in, serial_out, serial_out_oe;
    logic write_protect_n, array_busy, erase_paused_flag, program_paused_flag;
    logic write_latch, ready_busy_flag, guard_invert, four_lane_enable;
    logic [4:0] region_guard;
    logic [2:0] page_lock;
    logic [1:0] output_strength_field;
    logic [15:0] rx;
    int miscompares = 0;
    int n_compared = 0;

    fsr_bank u_dut (.core_clk(core_clk), .srst(srst), .serial_clk(serial_clk), .sel_n(sel_n),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
        .write_protect_n(write_protect_n), .array_busy(array_busy),
        .erase_paused_flag(erase_paused_flag), .program_paused_flag(program_paused_flag),
        .write_latch(write_latch), .ready_busy_flag(ready_busy_flag),
        .region_guard(region_guard), .guard_invert(guard_invert), .page_lock(page_lock),
        .four_lane_enable(four_lane_enable), .output_strength_field(output_strength_field));
    fsr_host_model u_host (.serial_clk(serial_clk), .sel_n(sel_n), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // Core clock, 50 MHz.
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Reads one status byte and compares it.
    task automatic rd(input logic [7:0] op, input logic [7:0] exp);
        u_host.xfer({op, 8'h00}, 8, 8, rx);
        chk(rx, {8'h00, exp});
    endtask

    // Enables writes, sends a write of n bits, then waits out any write cycle.
    task automatic wr(input logic [7:0] op, input logic [7:0] data, input int n);
        int k;
        u_host.xfer({OP_WRITE_ENABLE, 8'h00}, 8, 0, rx);
        @(negedge core_clk);
        chk(16'(write_latch), 16'h0001);
        u_host.xfer({op, data}, n, 0, rx);
        k = 0;
        while (ready_busy_flag !== 1'b0 && k < 700)
        begin
            @(negedge core_clk);
            k++;
        end
        if (k >= 700)
        begin
            miscompares++;
            wrap_up();
        end
    endtask

    // Reset, the table of ordinary cases, then the awkward ones.
    initial
    begin
        srst = 1'b1;
        write_protect_n = 1'b1;
        array_busy = 1'b0;
        erase_paused_flag = 1'b0;
        program_paused_flag = 1'b0;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        foreach (ROWS[i])
        begin
            if (ROWS[i].wr_op != 8'h00)
                wr(ROWS[i].wr_op, ROWS[i].data, 16);
            rd(ROWS[i].rd_op, ROWS[i].exp);
        end
        @(negedge core_clk);
        chk(16'(region_guard), 16'h001f);
        chk(16'(output_strength_field), 16'h0002);
        chk(16'(write_latch), 16'h0000);
        u_host.xfer({OP_WRITE_THREE, 8'h00}, 16, 0, rx);
        rd(OP_READ_THREE, 8'h40);
        wr(OP_WRITE_THREE, 8'h00, 15);
        rd(OP_READ_THREE, 8'h40);
        @(posedge core_clk);
        erase_paused_flag <= 1'b1;
        program_paused_flag <= 1'b1;
        rd(OP_READ_TWO, 8'h84);
        // Busy rises in mid-stream; only the repeat may show it.
        fork
            u_host.xfer({OP_READ_ONE, 8'h00}, 8, 16, rx);
            begin
                #1800;
                @(posedge core_clk);
                array_busy <= 1'b1;
            end
        join
        chk(rx, 16'h7c7d);
        @(posedge core_clk);
        array_busy <= 1'b0;
        erase_paused_flag <= 1'b0;
        program_paused_flag <= 1'b0;
        u_host.xfer({OP_READ_ONE, 8'h00}, 8, 3, rx);
        @(negedge core_clk);
        chk(16'(serial_out_oe), 16'h0000);
        chk(rx, 16'h0003);
        // Byte two fields reach their configuration outputs.
        wr(OP_WRITE_TWO, 8'h5a, 16);
        @(negedge core_clk);
        chk(16'(guard_invert), 16'h0001);
        chk(16'(page_lock), 16'h0003);
        chk(16'(four_lane_enable), 16'h0001);
        wr(OP_WRITE_ONE, 8'h80, 16);
        @(posedge core_clk);
        write_protect_n <= 1'b0;
        wr(OP_WRITE_THREE, 8'h60, 16);
        rd(OP_READ_THREE, 8'h40);
        @(posedge core_clk);
        write_protect_n <= 1'b1;
        wr(OP_WRITE_THREE, 8'h20, 16);
        rd(OP_READ_THREE, 8'h20);
        wr(OP_WRITE_TWO, 8'h01, 16);
        rd(OP_READ_TWO, 8'h01);
        wr(OP_WRITE_THREE, 8'h60, 16);
        rd(OP_READ_THREE, 8'h20);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        write_protect_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(OP_READ_ONE, 8'h00);
        rd(OP_READ_TWO, 8'h00);
        wr(OP_WRITE_THREE, 8'h40, 16);
        rd(OP_READ_THREE, 8'h40);
        wr(OP_WRITE_TWO, 8'h01, 16);
        wr(OP_WRITE_THREE, 8'h00, 16);
        rd(OP_READ_THREE, 8'h40);
        wrap_up();
    end
endmodule // flash_status_register_bank_bench
